// ### hw/tss_consts.vh
`ifndef TSS_CONSTS_VH
`define TSS_CONSTS_VH

// register byte addresses
`define TSS_ADDR_CTRL     12'h000
`define TSS_ADDR_STATUS   12'h004
`define TSS_ADDR_FLAGS    12'h008
`define TSS_ADDR_STARTS   12'h00C

// reset values
`define TSS_CTRL_RST      32'h0000_0001
`define TSS_STARTS_RST    16'h0000

// field positions
`define TSS_CTRL_EN_BIT   0
`define TSS_ST_STATE_LSB  0
`define TSS_ST_FAULT_BIT  4
`define TSS_ST_PG_LSB     8
`define TSS_ST_FAST_BIT   12
`define TSS_ST_SLOW_BIT   13
`define TSS_ST_UVLO_BIT   14

// timing
`define TSS_CLK_MHZ       125
`define TSS_T_RESET_NS    30000
`define TSS_GLITCH_CYC    16

`endif

// ### hw/tss_glitch.v
`timescale 1ns/1ps
`default_nettype none
`include "tss_consts.vh"

// low must persist CYC cycles before good drops; recovery is immediate
module tss_glitch #(
  parameter CYC = `TSS_GLITCH_CYC
) (
  input  wire pclk,
  input  wire presetn,
  input  wire fb_ok,
  output wire good
);

  localparam CW = 8;

  reg [CW-1:0] cnt_r;
  reg          good_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= {CW{1'b0}};
      good_r <= 1'b0;
    end else if (fb_ok) begin
      cnt_r  <= {CW{1'b0}};
      good_r <= 1'b1;
    end else if (cnt_r >= CYC[CW-1:0] - 8'd1) begin
      good_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_r + 8'd1;
    end
  end

  assign good = good_r;

endmodule // tss_glitch

`default_nettype wire

// ### hw/tss_sequencer.v
// Function
// - any supply low forces lockout unless faulted, gates low
// - exit lockout needs all supplies up, enable
// - channel one good held until soft-start ends
// - channels two, three follow feedback after lockout
// - feedback low filtered; high releases immediately
// - timer discharged when idle, charged when timing
// - timer threshold ends period, discharges timer
// - before start gates, timer, filter held low
// - all gates off before first timing cycle
// - filter low and fault high start second cycle
// - second cycle arms fast comparators, gate charge
// - end of cycle: good one, slow arm, monitor
// - sense drop throttles gate charge in soft-start
// - fault input level gates second cycle start
// - enable low drops gates; long low clears breakers
// - fault status latched until enable low long
`timescale 1ns/1ps
`default_nettype none
`include "tss_consts.vh"

module tss_sequencer #(
  parameter GLITCH_CYC = `TSS_GLITCH_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // comparator flags from the analog front end
  input  wire [2:0]  supply_ok_in,
  input  wire        enable_comparator_in,
  input  wire [2:0]  gate_off_in,
  input  wire        timer_high_comparator_in,
  input  wire        filter_low_in,
  input  wire        fault_input_comparator_in,
  input  wire [2:0]  output_feedback_in,
  input  wire [2:0]  sense_drop_in,
  input  wire [2:0]  fast_overcurrent_comparator_in,
  input  wire [2:0]  slow_overcurrent_comparator_in,
  // controls to the analog front end
  output wire [2:0]  pass_switch_drive_charge,
  output wire [2:0]  pass_switch_drive_pulldown,
  output wire        timer_charge,
  output wire        timer_discharge,
  output wire        filter_pulldown,
  output wire        fast_overcurrent_arm,
  output wire        slow_overcurrent_arm,
  // open-drain outputs
  output wire [2:0]  power_good_out_o,
  output wire [2:0]  power_good_out_oe,
  output wire        fault_out_o,
  output wire        fault_out_oe
);

  localparam [2:0] ST_LOCKOUT = 3'd0;
  localparam [2:0] ST_CHECK   = 3'd1;
  localparam [2:0] ST_TIMER1  = 3'd2;
  localparam [2:0] ST_WAIT    = 3'd3;
  localparam [2:0] ST_SOFT    = 3'd4;
  localparam [2:0] ST_MONITOR = 3'd5;
  localparam [2:0] ST_FAULT   = 3'd6;

  // least time: round up to whole cycles
  localparam integer RESET_CYC =
    (`TSS_T_RESET_NS * `TSS_CLK_MHZ + 999) / 1000;
  localparam         RW = 12;

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  wire [21:0] raw_flags;
  wire [21:0] s_flags;

  assign raw_flags = {slow_overcurrent_comparator_in,
                      fast_overcurrent_comparator_in,
                      sense_drop_in,
                      output_feedback_in,
                      fault_input_comparator_in,
                      filter_low_in,
                      timer_high_comparator_in,
                      gate_off_in,
                      enable_comparator_in,
                      supply_ok_in};

  tss_sync #(
    .W (22)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (raw_flags),
    .q       (s_flags)
  );

  wire [2:0] s_supply;
  wire       s_enable;
  wire [2:0] s_gate_off;
  wire       s_tmr_hi;
  wire       s_filt_low;
  wire       s_fault_in;
  wire [2:0] s_fb;
  wire [2:0] s_sdrop;
  wire [2:0] s_fast;
  wire [2:0] s_slow;

  assign s_supply   = s_flags[2:0];
  assign s_enable   = s_flags[3];
  assign s_gate_off = s_flags[6:4];
  assign s_tmr_hi   = s_flags[7];
  assign s_filt_low = s_flags[8];
  assign s_fault_in = s_flags[9];
  assign s_fb       = s_flags[12:10];
  assign s_sdrop    = s_flags[15:13];
  assign s_fast     = s_flags[18:16];
  assign s_slow     = s_flags[21:19];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  reg  [31:0] ctrl_r;
  reg  [31:0] prdata_r;
  reg  [15:0] starts_r;
  wire        sw_enable;
  wire        en_ok;
  wire        uvlo;

  assign sw_enable = ctrl_r[`TSS_CTRL_EN_BIT];
  // supply flags come from hysteretic comparators
  assign uvlo      = ~&s_supply;
  assign en_ok     = s_enable & sw_enable;

  // ---------------------------------------------------------------
  // enable-low timer and fault latch
  // ---------------------------------------------------------------
  reg  [RW-1:0] en_low_cnt_r;
  reg           fault_r;
  wire          en_long_low;
  wire          trip;
  wire          armed_fast;
  wire          armed_slow;
  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;

  assign en_long_low = (en_low_cnt_r == RESET_CYC[RW-1:0]);
  assign armed_fast  = (state_r == ST_SOFT) | (state_r == ST_MONITOR);
  assign armed_slow  = (state_r == ST_MONITOR);
  // lost fault level in monitor trips all breakers
  assign trip = (armed_fast & |s_fast) |
                (armed_slow & |s_slow) |
                (armed_slow & ~s_fault_in);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_low_cnt_r <= {RW{1'b0}};
    end else if (en_ok) begin
      en_low_cnt_r <= {RW{1'b0}};
    end else if (!en_long_low) begin
      en_low_cnt_r <= en_low_cnt_r + 12'h001;
    end
  end

  // a trip in the clearing cycle keeps the latch set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
    end else if (trip) begin
      fault_r <= 1'b1;
    end else if (en_long_low) begin
      fault_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOCKOUT: begin
        if (!uvlo && en_ok && !fault_r)
          state_nxt = ST_CHECK;
      end
      ST_CHECK: begin
        if (&s_gate_off)
          state_nxt = ST_TIMER1;
      end
      ST_TIMER1: begin
        if (s_tmr_hi)
          state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        // timer must ramp down before the start checks
        if (!s_tmr_hi && s_filt_low && s_fault_in)
          state_nxt = ST_SOFT;
      end
      ST_SOFT: begin
        if (trip)
          state_nxt = ST_FAULT;
        else if (s_tmr_hi)
          state_nxt = ST_MONITOR;
      end
      ST_MONITOR: begin
        if (trip)
          state_nxt = ST_FAULT;
      end
      ST_FAULT: begin
        if (!fault_r)
          state_nxt = ST_LOCKOUT;
      end
      default: begin
        state_nxt = ST_LOCKOUT;
      end
    endcase
    // fault state stays latched through a short enable pulse
    if ((uvlo || !en_ok) && state_nxt != ST_FAULT)
      state_nxt = ST_LOCKOUT;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_r <= ST_LOCKOUT;
    else
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // output registers, driven from the next state
  // ---------------------------------------------------------------
  reg  [2:0] gate_charge_r;
  reg  [2:0] gate_pull_r;
  reg        tmr_charge_r;
  reg        filt_pull_r;
  reg        fast_arm_r;
  reg        slow_arm_r;
  wire       nxt_on;
  wire       nxt_soft;
  wire       nxt_mon;

  assign nxt_soft = (state_nxt == ST_SOFT);
  assign nxt_mon  = (state_nxt == ST_MONITOR);
  assign nxt_on   = nxt_soft | nxt_mon;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_charge_r <= 3'b000;
      gate_pull_r   <= 3'b111;
      tmr_charge_r  <= 1'b0;
      filt_pull_r   <= 1'b1;
      fast_arm_r    <= 1'b0;
      slow_arm_r    <= 1'b0;
    end else begin
      // servo: drop charge while sense drop exceeds the limit
      gate_charge_r <= nxt_mon ? 3'b111 :
                       (nxt_soft ? ~s_sdrop : 3'b000);
      gate_pull_r   <= nxt_on ? 3'b000 : 3'b111;
      tmr_charge_r  <= (state_nxt == ST_TIMER1) | nxt_soft;
      // let the filter node rise only on a slow overcurrent
      filt_pull_r   <= ~(nxt_mon & |s_slow);
      fast_arm_r    <= nxt_on;
      slow_arm_r    <= nxt_mon;
    end
  end

  assign pass_switch_drive_charge   = gate_charge_r;
  assign pass_switch_drive_pulldown = gate_pull_r;
  assign timer_charge               = tmr_charge_r;
  assign timer_discharge            = ~tmr_charge_r;
  assign filter_pulldown            = filt_pull_r;
  assign fast_overcurrent_arm       = fast_arm_r;
  assign slow_overcurrent_arm       = slow_arm_r;

  // ---------------------------------------------------------------
  // power-good outputs
  // ---------------------------------------------------------------
  wire [2:0] fb_good;
  reg  [2:0] pg_r;
  reg        fault_oe_r;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_fb
      tss_glitch #(
        .CYC (GLITCH_CYC)
      ) u_glitch (
        .pclk    (pclk),
        .presetn (presetn),
        .fb_ok   (s_fb[gi]),
        .good    (fb_good[gi])
      );
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_r       <= 3'b000;
      fault_oe_r <= 1'b0;
    end else begin
      pg_r[0]    <= (state_r == ST_MONITOR) & fb_good[0];
      pg_r[1]    <= (state_r != ST_LOCKOUT) & fb_good[1];
      pg_r[2]    <= (state_r != ST_LOCKOUT) & fb_good[2];
      fault_oe_r <= fault_r;
    end
  end

  assign power_good_out_o  = 3'b000;
  assign power_good_out_oe = ~pg_r;
  assign fault_out_o       = 1'b0;
  assign fault_out_oe      = fault_oe_r;

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  wire        setup;
  wire        access;
  wire        hit;
  wire [31:0] status_w;
  reg  [31:0] rd_mux;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign hit    = (paddr == `TSS_ADDR_CTRL)   |
                  (paddr == `TSS_ADDR_STATUS) |
                  (paddr == `TSS_ADDR_FLAGS)  |
                  (paddr == `TSS_ADDR_STARTS);

  assign status_w = {17'h0_0000,
                     uvlo,
                     slow_arm_r,
                     fast_arm_r,
                     1'b0,
                     pg_r,
                     3'b000,
                     fault_r,
                     1'b0,
                     state_r};

  always @* begin
    case (paddr)
      `TSS_ADDR_CTRL:   rd_mux = ctrl_r;
      `TSS_ADDR_STATUS: rd_mux = status_w;
      `TSS_ADDR_FLAGS:  rd_mux = {10'h000, s_flags};
      `TSS_ADDR_STARTS: rd_mux = {16'h0000, starts_r};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `TSS_CTRL_RST;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (setup)
        prdata_r <= rd_mux;
      if (access && pwrite && paddr == `TSS_ADDR_CTRL)
        ctrl_r <= {31'h0000_0000, pwdata[`TSS_CTRL_EN_BIT]};
    end
  end

  // counts completed start-ups; wraps
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      starts_r <= `TSS_STARTS_RST;
    else if (state_r == ST_SOFT && state_nxt == ST_MONITOR)
      starts_r <= starts_r + 16'h0001;
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

endmodule // tss_sequencer

`default_nettype wire

// ### hw/tss_sync.v
`timescale 1ns/1ps
`default_nettype none

module tss_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule // tss_sync

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tss_consts.vh"
`define CHK(n, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); \
  end \
end
`define WAITU(c) begin \
  repeat (4000) if ((c) !== 1'b1) @(posedge pclk); \
  if ((c) !== 1'b1) fail_count++; \
end

module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [2:0]  supply, gate_off, fb, sdrop, fast, slow, chg, pd, pg_oe, fb_drop;
  logic        en, tmr_hi, flt_low, fault_in, tchg, tdis, fpd, farm, sarm, foe;
  logic [2:0]  pg_o;
  logic        fo;
  int          fail_count = 0;
  int          checks = 0;

  always #4 pclk = ~pclk;

  tss_sequencer #(.GLITCH_CYC(4)) u_tss_sequencer (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_ok_in(supply),
    .enable_comparator_in(en), .gate_off_in(gate_off),
    .timer_high_comparator_in(tmr_hi), .filter_low_in(flt_low),
    .fault_input_comparator_in(fault_in), .output_feedback_in(fb),
    .sense_drop_in(sdrop), .fast_overcurrent_comparator_in(fast),
    .slow_overcurrent_comparator_in(slow), .pass_switch_drive_charge(chg),
    .pass_switch_drive_pulldown(pd), .timer_charge(tchg),
    .timer_discharge(tdis), .filter_pulldown(fpd),
    .fast_overcurrent_arm(farm), .slow_overcurrent_arm(sarm),
    .power_good_out_o(pg_o), .power_good_out_oe(pg_oe), .fault_out_o(fo),
    .fault_out_oe(foe));

  tss_afe_model #(.TMR_CYC(20)) u_tss_afe_model (
    .pclk(pclk), .presetn(presetn), .drive_pulldown(pd), .timer_charge(tchg),
    .timer_discharge(tdis), .fb_drop(fb_drop), .gate_off(gate_off),
    .timer_high(tmr_hi), .feedback(fb));

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    fail_count++;
    tally_and_finish;
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0000_0000; supply = 3'h0; en = 0;
    flt_low = 0; fault_in = 1; sdrop = 3'h0; fast = 3'h0; slow = 3'h0;
    fb_drop = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    `CHK("pulldown", 3'h7, pd)
    `CHK("tmr_dis", 1'b1, tdis)
    `CHK("filt_pd", 1'b1, fpd)
    `CHK("good_oe", 3'h7, pg_oe)
    `CHK("od_low", 4'h0, {pg_o, fo})
    apb(0, `TSS_ADDR_CTRL, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_0001, rd_data)
    apb(0, 12'h010, 32'h0000_0000);
    `CHK("unmapped", 1'b1, rd_err)
    apb(1, `TSS_ADDR_STARTS, 32'hFFFF_FFFF);
    apb(0, `TSS_ADDR_STARTS, 32'h0000_0000);
    `CHK("starts0", 32'h0000_0000, rd_data)
    supply <= 3'h7;
    en <= 1'b1;
    sdrop <= 3'h2;
    `WAITU(tchg)
    cyc(1);
    `CHK("t1_pd", 3'h7, pd)
    `WAITU(!tchg)
    cyc(20);
    `CHK("wait_arm", 1'b0, farm)
    fault_in <= 1'b0;
    flt_low <= 1'b1;
    cyc(8);
    `CHK("uv_hold", 1'b0, farm)
    fault_in <= 1'b1;
    `WAITU(farm)
    cyc(8);
    `CHK("soft_chg", 3'h5, chg)
    `CHK("soft_good", 3'h1, pg_oe)
    sdrop <= 3'h0;
    `WAITU(sarm)
    cyc(6);
    `CHK("mon_chg", 3'h7, chg)
    `CHK("mon_good", 3'h0, pg_oe)
    apb(0, `TSS_ADDR_STARTS, 32'h0000_0000);
    `CHK("starts1", 32'h0000_0001, rd_data)
    apb(0, `TSS_ADDR_STATUS, 32'h0000_0000);
    `CHK("status", 32'h0000_3705, rd_data)
    apb(0, `TSS_ADDR_FLAGS, 32'h0000_0000);
    `CHK("flags", 32'h0000_1F0F, rd_data)
    fb_drop <= 3'h2;
    cyc(1);
    fb_drop <= 3'h0;
    cyc(8);
    `CHK("glitch", 1'b0, pg_oe[1])
    fb_drop <= 3'h2;
    cyc(14);
    `CHK("drop", 1'b1, pg_oe[1])
    fb_drop <= 3'h0;
    cyc(6);
    `CHK("recover", 1'b0, pg_oe[1])
    fault_in <= 1'b0;
    cyc(8);
    `CHK("fault", 1'b1, foe)
    `CHK("fault_pd", 3'h7, pd)
    en <= 1'b0;
    fault_in <= 1'b1;
    cyc(100);
    en <= 1'b1;
    cyc(8);
    `CHK("latched", 1'b1, foe)
    en <= 1'b0;
    cyc(3800);
    `CHK("cleared", 1'b0, foe)
    en <= 1'b1;
    `WAITU(sarm)
    `CHK("restart", 1'b1, sarm)
    cyc(1);
    supply <= 3'h3;
    cyc(8);
    `CHK("uvlo_pd", 3'h7, pd)
    `CHK("uvlo_good", 3'h7, pg_oe)
    apb(1, `TSS_ADDR_CTRL, 32'h0000_0000);
    supply <= 3'h7;
    cyc(20);
    `CHK("sw_off", 1'b0, tchg)
    apb(1, `TSS_ADDR_CTRL, 32'h0000_0001);
    `WAITU(tchg)
    `CHK("sw_on", 1'b1, tchg)
    `WAITU(farm)
    fast <= 3'h4;
    cyc(8);
    `CHK("fast_trip", 1'b1, foe)
    `CHK("fast_pd", 3'h7, pd)
    tally_and_finish;
  end
endmodule // testbench

`default_nettype wire

// ### tb/tss_afe_model.sv
`timescale 1ns/1ps
`default_nettype none

module tss_afe_model #(
  parameter TMR_CYC = 20
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] drive_pulldown,
  input  wire logic       timer_charge,
  input  wire logic       timer_discharge,
  input  wire logic [2:0] fb_drop,
  output wire logic [2:0] gate_off,
  output wire logic       timer_high,
  output wire logic [2:0] feedback
);
  logic [2:0] gate_off_r;
  logic [7:0] tmr_r;
  // gate lags the pull-down by a cycle, as a real node would
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_off_r <= 3'h7;
      tmr_r      <= 8'h00;
    end else begin
      gate_off_r <= drive_pulldown;
      if (timer_discharge) begin
        tmr_r <= 8'h00;
      end else if (timer_charge && tmr_r != TMR_CYC) begin
        tmr_r <= tmr_r + 8'h01;
      end
    end
  end
  assign gate_off   = gate_off_r;
  assign timer_high = (tmr_r == TMR_CYC);
  // rail only rises with the pass switch on
  assign feedback   = ~gate_off_r & ~fb_drop;
endmodule // tss_afe_model

`default_nettype wire

// ### tb/tss_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module tss_seq_asserts #(
  parameter GLITCH_CYC = 16,
  parameter RST_CYC    = 3750
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [2:0] supply_ok_in,
  input wire logic       enable_comparator_in,
  input wire logic       filter_low_in,
  input wire logic       fault_input_comparator_in,
  input wire logic       timer_high_comparator_in,
  input wire logic [2:0] output_feedback_in,
  input wire logic [2:0] pass_switch_drive_charge,
  input wire logic [2:0] pass_switch_drive_pulldown,
  input wire logic       timer_charge,
  input wire logic       timer_discharge,
  input wire logic       fast_overcurrent_arm,
  input wire logic       slow_overcurrent_arm,
  input wire logic [2:0] power_good_out_oe,
  input wire logic       fault_out_oe
);
  logic [11:0] lo_cnt_r;
  logic [11:0] hi_cnt_r;
  logic [11:0] en_lo_cnt_r;
  // saturating run lengths of raw inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt_r    <= 12'h000;
      hi_cnt_r    <= 12'h000;
      en_lo_cnt_r <= 12'h000;
    end else begin
      lo_cnt_r    <= output_feedback_in[1] ? 12'h000 :
                     lo_cnt_r + {11'h000, ~&lo_cnt_r};
      hi_cnt_r    <= !output_feedback_in[1] ? 12'h000 :
                     hi_cnt_r + {11'h000, ~&hi_cnt_r};
      en_lo_cnt_r <= enable_comparator_in ? 12'h000 :
                     en_lo_cnt_r + {11'h000, ~&en_lo_cnt_r};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_supply_lost;
    (~&supply_ok_in)[*5];
  endsequence
  sequence s_enable_off;
    (!enable_comparator_in)[*5];
  endsequence

  chk_lockout_gates: assert property (s_supply_lost |->
    pass_switch_drive_pulldown == 3'h7 && pass_switch_drive_charge == 3'h0)
    else $error("gates not low in lockout");
  chk_lockout_good: assert property (s_supply_lost ##1 1'b1 |->
    &power_good_out_oe) else $error("good released in lockout");
  chk_enable_off: assert property (s_enable_off |->
    pass_switch_drive_pulldown == 3'h7) else $error("gates on, enable low");
  chk_timer_node: assert property (s_supply_lost |->
    !timer_charge && timer_discharge) else $error("timer charged in lockout");
  chk_timer_end: assert property (timer_high_comparator_in[*4] |->
    !timer_charge) else $error("timer charging past threshold");
  chk_soft_entry: assert property ($rose(fast_overcurrent_arm) |->
    $past(filter_low_in, 3) && $past(fault_input_comparator_in, 3) &&
    pass_switch_drive_pulldown == 3'h0) else $error("bad soft-start entry");
  chk_monitor_entry: assert property ($rose(slow_overcurrent_arm) |->
    fast_overcurrent_arm && pass_switch_drive_charge == 3'h7)
    else $error("bad monitor entry");
  chk_first_good: assert property ($fell(power_good_out_oe[0]) |->
    $past(slow_overcurrent_arm)) else $error("channel one good too early");
  chk_glitch_hold: assert property ($rose(power_good_out_oe[1]) &&
    $past(slow_overcurrent_arm) |-> lo_cnt_r >= GLITCH_CYC)
    else $error("good dropped without filter");
  chk_good_release: assert property ($fell(power_good_out_oe[1]) |->
    hi_cnt_r >= 12'h002) else $error("good released without feedback");
  chk_fault_clear: assert property ($fell(fault_out_oe) |->
    en_lo_cnt_r >= RST_CYC) else $error("fault cleared too soon");
endmodule // tss_seq_asserts

bind tss_sequencer tss_seq_asserts #(.GLITCH_CYC(GLITCH_CYC)) u_chk (
  .pclk, .presetn, .supply_ok_in, .enable_comparator_in, .filter_low_in,
  .fault_input_comparator_in, .timer_high_comparator_in, .output_feedback_in,
  .pass_switch_drive_charge, .pass_switch_drive_pulldown, .timer_charge,
  .timer_discharge, .fast_overcurrent_arm, .slow_overcurrent_arm,
  .power_good_out_oe, .fault_out_oe);

`default_nettype wire
